// ### verilog/gpio_pair_consts.svh
// Named constants for the general pin pair configuration block
`ifndef GPIO_PAIR_CONSTS_SVH
`define GPIO_PAIR_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (printed index 81h is not a multiple of four)
// ----------------------------------------------------------------
`define CFG_INDEX 12'h081
`define ADDR_CFG 12'h204
`define ADDR_STATUS 12'h000
`define ADDR_W 12

// ----------------------------------------------------------------
// Configuration word layout and reset
// ----------------------------------------------------------------
`define CFG_W 16
`define CFG_RESET 16'h0000
`define CFG_RO_ONE 16'h8000
`define CFG_WR_MASK 16'h7FFF
`define DAT_LSB 0
`define TB_LSB 4
`define TB_STRIDE 2
`define DIR_LSB 8
`define FMT_LSB 10
`define STAT_W 6

// ----------------------------------------------------------------
// Time base periods in master clock cycles
// ----------------------------------------------------------------
`define TB_W 11
`define TB_CODE_16 11'h010
`define TB_CODE_64 11'h040
`define TB_CODE_256 11'h100
`define TB_CODE_1024 11'h400
`define TB_ONE 11'h001
`define PWM_CNT_W 7
`define PWM_CNT_MAX 7'h7F
`define PWM_CNT_ONE 7'h01

// ----------------------------------------------------------------
// AXI4-Lite answers
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/gpio_pair_pkg.sv
// Types and shared decoding for the general pin pair block
`include "gpio_pair_consts.svh"

package gpio_pair_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [1:0] tb_code_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`CFG_W-1:0] cfg_t;
	typedef logic [`TB_W-1:0] tb_count_t;
	typedef enum logic {PIN_INPUT, PIN_OUTPUT} pin_dir_t;

	// ----------------------------------------------------------------
	// Time base code to master clock periods per unit
	// ----------------------------------------------------------------
	function automatic tb_count_t tb_period(input tb_code_t code);
		case (code)
			2'h0: tb_period = `TB_CODE_16;
			2'h1: tb_period = `TB_CODE_64;
			2'h2: tb_period = `TB_CODE_256;
			default: tb_period = `TB_CODE_1024;
		endcase
	endfunction

endpackage

// ### verilog/reg_bus_if.sv
// Internal register access carrier between bus slave and register file
`include "gpio_pair_consts.svh"
interface reg_bus_if;
	logic wr_en;
	logic [`ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic [`ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;

	modport axi (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
		input wr_hit, input rd_data, input rd_hit);
	modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
		output wr_hit, output rd_data, output rd_hit);
endinterface

// ### verilog/axil_reg_slave.sv
// AXI4-Lite slave that turns bus transfers into register accesses
`include "gpio_pair_consts.svh"
module axil_reg_slave (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic [`ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [`ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	reg_bus_if.axi rb
);
	import gpio_pair_pkg::*;

	logic aw_held_q;
	logic w_held_q;
	addr_t awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ----------------------------------------------------------------
	// Handshakes: address and data are taken in either order
	// ----------------------------------------------------------------
	assign o_awready = !aw_held_q && !bvalid_q;
	assign o_wready = !w_held_q && !bvalid_q;
	assign o_arready = !rvalid_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	// Register write fires once both halves are held
	assign rb.wr_en = aw_held_q && w_held_q && !bvalid_q && i_clk_en;
	assign rb.wr_addr = awaddr_q;
	assign rb.wr_data = wdata_q;
	assign rb.wr_strb = wstrb_q;
	assign rb.rd_addr = i_araddr;

	// Write address capture
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end else if (i_clk_en) begin
			if (i_awvalid && o_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end else if (rb.wr_en) begin
				aw_held_q <= 1'b0;
			end
		end
	end

	// Write data capture
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (i_clk_en) begin
			if (i_wvalid && o_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end else if (rb.wr_en) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (i_clk_en) begin
			if (rb.wr_en) begin
				bvalid_q <= 1'b1;
				bresp_q <= rb.wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read: data sampled at the address handshake, answered next cycle
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RESP_OKAY;
		end else if (i_clk_en) begin
			if (i_arvalid && o_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rb.rd_hit ? rb.rd_data : 32'h0000_0000;
				rresp_q <= rb.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (i_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule

// ### verilog/pwm_level_decoder.sv
// Decodes one pin's PWM input into a logic level
`include "gpio_pair_consts.svh"
module pwm_level_decoder (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_enable,
	input wire logic i_level,
	input wire gpio_pair_pkg::tb_code_t i_tb_code,
	output logic o_level
);
	import gpio_pair_pkg::*;

	tb_count_t pre_q;
	logic tick;
	logic prev_q;
	logic rise;
	logic [`PWM_CNT_W-1:0] high_q;
	logic [`PWM_CNT_W-1:0] low_q;
	logic sat;
	logic level_q;

	// ----------------------------------------------------------------
	// Time base prescaler, one tick per selected unit
	// ----------------------------------------------------------------
	assign tick = (pre_q == tb_period(i_tb_code) - `TB_ONE);
	assign rise = i_level && !prev_q;
	// Saturation marks a line stuck at one level, read as static
	assign sat = (high_q == `PWM_CNT_MAX) || (low_q == `PWM_CNT_MAX);
	assign o_level = level_q;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pre_q <= '0;
		end else if (i_clk_en) begin
			if (!i_enable || tick || rise) begin
				pre_q <= '0; // Restart on a rising edge so units align to the period start
			end else begin
				pre_q <= pre_q + `TB_ONE;
			end
		end
	end

	// Edge tracking
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_q <= 1'b0;
		end else if (i_clk_en) begin
			prev_q <= i_level;
		end
	end

	// High and low duration counters in time base units
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			high_q <= '0;
			low_q <= '0;
		end else if (i_clk_en) begin
			if (!i_enable || rise || sat) begin
				high_q <= '0;
				low_q <= '0;
			end else if (tick) begin
				if (i_level) begin
					high_q <= high_q + `PWM_CNT_ONE;
				end else begin
					low_q <= low_q + `PWM_CNT_ONE;
				end
			end
		end
	end

	// Level decision at each period end: high time longer than low time reads as 1
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			level_q <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_enable) begin
				level_q <= 1'b0;
			end else if (rise || sat) begin
				level_q <= (high_q > low_q);
			end
		end
	end
endmodule

// ### verilog/gpio_pair_config_pwm_decode.sv
// Configuration register and pin logic for the general pin pair
// What this block does
// - Direction bit 0 makes a pin input, 1 output; pin1 bit9, pin0 bit8; reset input.
// - Input format bit: 0 static level, 1 PWM decoded; pin1 bit11, pin0 bit10.
// - No PWM output; an output pin drives a static level whatever its format bit.
// - Time base codes 00..11 give 16, 64, 256, 1024 clocks; pin1 bits7:6, pin0 5:4.
// - An output pin drives its output value bit; pin1 bit1, pin0 bit0.
// - Output value bit has no pin effect while input, but is stored and read back.
// - Spare bits 14:12 and 3:2 are read/write, reset zero, with no effect.
// - PWM period is high plus low count times time base; high time is high count.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`include "gpio_pair_consts.svh"
module gpio_pair_config_pwm_decode (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire gpio_pair_pkg::addr_t i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire gpio_pair_pkg::addr_t i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [1:0] i_general_pin_in,
	output logic [1:0] o_general_pin_out,
	output logic [1:0] o_general_pin_oe_n,
	output logic [1:0] o_pin_level
);
	import gpio_pair_pkg::*;

	reg_bus_if rb ();

	cfg_t cfg_q;
	cfg_t cfg_view;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] pwm_level;
	logic [1:0] out_q;
	logic [1:0] oe_n_q;
	logic [1:0] level_q;
	logic [1:0] dir_bits;
	logic [1:0] fmt_bits;
	logic [1:0] dat_bits;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	axil_reg_slave u_slave (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_clk_en(i_clk_en),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.rb(rb.axi)
	);

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	// Bit 15 is fixed at one and never stored
	assign cfg_view = cfg_q | `CFG_RO_ONE;
	assign rb.wr_hit = (rb.wr_addr == `ADDR_CFG) || (rb.wr_addr == `ADDR_STATUS);
	assign rb.rd_hit = (rb.rd_addr == `ADDR_CFG) || (rb.rd_addr == `ADDR_STATUS);

	// Readback; status shows live pin and decode state, writes to it are ignored
	always_comb begin
		rb.rd_data = 32'h0000_0000;
		if (rb.rd_addr == `ADDR_CFG) begin
			rb.rd_data[`CFG_W-1:0] = cfg_view;
		end else if (rb.rd_addr == `ADDR_STATUS) begin
			rb.rd_data[`STAT_W-1:0] = {pwm_level, sync2_q, level_q};
		end
	end

	// Byte lanes 0 and 1 update the stored word, spares included
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_q <= `CFG_RESET;
		end else if (i_clk_en && rb.wr_en && rb.wr_addr == `ADDR_CFG) begin
			if (rb.wr_strb[0]) begin
				cfg_q[7:0] <= rb.wr_data[7:0];
			end
			if (rb.wr_strb[1]) begin
				// Bit 15 is never stored, the readback supplies it
				cfg_q[15:8] <= {1'b0, rb.wr_data[14:8]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (i_clk_en) begin
			sync1_q <= i_general_pin_in;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Per pin decode and drive
	// ----------------------------------------------------------------
	assign o_general_pin_out = out_q;
	assign o_general_pin_oe_n = oe_n_q;
	assign o_pin_level = level_q;

	for (genvar p = 0; p < 2; p++) begin : g_pin
		assign dir_bits[p] = cfg_q[`DIR_LSB + p];
		assign fmt_bits[p] = cfg_q[`FMT_LSB + p];
		assign dat_bits[p] = cfg_q[`DAT_LSB + p];

		// Decoder runs only for an input pin set to PWM format
		pwm_level_decoder u_dec (
			.i_clock(i_clock),
			.i_arst_n(i_arst_n),
			.i_clk_en(i_clk_en),
			.i_enable(dir_bits[p] == PIN_INPUT && fmt_bits[p]),
			.i_level(sync2_q[p]),
			.i_tb_code(cfg_q[`TB_LSB + `TB_STRIDE * p +: 2]),
			.o_level(pwm_level[p])
		);

		// Driver: static level only, the format bit never reaches the pin
		always_ff @(posedge i_clock or negedge i_arst_n) begin
			if (!i_arst_n) begin
				out_q[p] <= 1'b0;
				oe_n_q[p] <= 1'b1;
			end else if (i_clk_en) begin
				oe_n_q[p] <= (dir_bits[p] == PIN_INPUT);
				out_q[p] <= (dir_bits[p] == PIN_OUTPUT) && dat_bits[p];
			end
		end

		// Logic level seen by the device: static, PWM decoded or own drive
		always_ff @(posedge i_clock or negedge i_arst_n) begin
			if (!i_arst_n) begin
				level_q[p] <= 1'b0;
			end else if (i_clk_en) begin
				if (dir_bits[p] == PIN_OUTPUT) begin
					level_q[p] <= dat_bits[p];
				end else if (fmt_bits[p]) begin
					level_q[p] <= pwm_level[p];
				end else begin
					level_q[p] <= sync2_q[p];
				end
			end
		end
	end
endmodule

// ### dv/gpio_pair_asserts.sv
// Bus handshake and pin drive assertions for the general pin pair block
`include "gpio_pair_consts.svh"
module gpio_pair_asserts (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire gpio_pair_pkg::addr_t i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [1:0] o_general_pin_out,
	input wire logic [1:0] o_general_pin_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import gpio_pair_pkg::*;
	// ----------------------------------------------------------------
	// Clocking and transfer steps
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);
	// Clock enable is part of the take, since a frozen slave answers nothing
	sequence rd_take;
		i_arvalid && o_arready && i_clk_en;
	endsequence
	sequence wr_take;
		i_awvalid && o_awready && i_wvalid && o_wready && i_clk_en;
	endsequence
	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	// Answers stand until accepted, the slave refuses while busy
	b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped early");
	r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read answer dropped early");
	rd_ans_a: assert property (rd_take |=> o_rvalid)
		else $error("read answer late");
	wr_ans_a: assert property (wr_take |-> ##[1:2] o_bvalid)
		else $error("write answer late");
	wr_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while answer pending");
	rd_busy_a: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while answer pending");
	unmap_rd_a: assert property (rd_take ##0 (i_araddr != `ADDR_CFG && i_araddr != `ADDR_STATUS)
		|=> o_rresp == `RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read answered");
	cfg_top_a: assert property (rd_take ##0 (i_araddr == `ADDR_CFG) |=> o_rdata[31:15] == 17'h00001)
		else $error("config upper bits wrong");
	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// A released pin never carries a stale drive level
	drive_off_a: assert property ((o_general_pin_out & o_general_pin_oe_n) == 2'h0)
		else $error("input pin drives a level");
	pin_cause_a: assert property ($changed({o_general_pin_out, o_general_pin_oe_n}) |-> $past(o_bvalid))
		else $error("pin drive changed without a write");
endmodule

bind gpio_pair_config_pwm_decode gpio_pair_asserts chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
	.i_clk_en(i_clk_en), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
	.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
	.i_rready(i_rready), .o_general_pin_out(o_general_pin_out), .o_general_pin_oe_n(o_general_pin_oe_n));

// ### dv/pin_partner.sv
// External logic on the two general pins: static levels or a PWM source
module pin_partner (
	input wire logic i_clock,
	input wire logic [1:0] i_oe_n,
	input wire logic [1:0] i_drive,
	input wire logic [1:0] i_static,
	input wire logic [1:0] i_pwm_sel,
	input int i_high_cycles,
	input int i_low_cycles,
	output logic [1:0] o_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	int count_q = 0;
	logic pwm_q = 1'b0;
	// PWM source, period is high plus low cycles
	always @(posedge i_clock) begin
		if (count_q + 1 >= (pwm_q ? i_high_cycles : i_low_cycles)) begin
			pwm_q <= !pwm_q;
			count_q <= 0;
		end else begin
			count_q <= count_q + 1;
		end
	end
	// Device drive wins while enabled, otherwise the outside level shows
	assign o_wire = (~i_oe_n & i_drive) | (i_oe_n & ((i_pwm_sel & {2{pwm_q}}) | (~i_pwm_sel & i_static)));
endmodule

// ### dv/gpio_pair_config_pwm_decode_tb.sv
// Self-checking bench for the general pin pair block
`include "gpio_pair_consts.svh"
module gpio_pair_config_pwm_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpio_pair_pkg::*;
	logic i_clock = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	addr_t i_awaddr = '0, i_araddr = '0;
	logic [31:0] i_wdata = '0;
	logic [3:0] i_wstrb = '0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp, o_general_pin_out, o_general_pin_oe_n, o_pin_level;
	logic [31:0] o_rdata;
	wire logic [1:0] i_general_pin_in;
	logic [1:0] stat = 2'h2, sel = 2'h0;
	int hi = 8, lo = 8, num_errors = 0, checked = 0;
	logic [33:0] wr_q[$], rd_q[$];

	gpio_pair_config_pwm_decode uut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .i_general_pin_in(i_general_pin_in),
		.o_general_pin_out(o_general_pin_out), .o_general_pin_oe_n(o_general_pin_oe_n), .o_pin_level(o_pin_level));
	pin_partner partner (.i_clock(i_clock), .i_oe_n(o_general_pin_oe_n), .i_drive(o_general_pin_out),
		.i_static(stat), .i_pwm_sel(sel), .i_high_cycles(hi), .i_low_cycles(lo), .o_wire(i_general_pin_in));

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus master
	// ----------------------------------------------------------------
	// Each task starts on a fresh edge so strobes are never set twice in one step
	task automatic axi_write(input addr_t a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		int n;
		@(posedge i_clock);
		wr_q.push_back({32'h0, r});
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= s;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while ((i_awvalid || i_wvalid || !o_bvalid) && n < 40);
		i_bready <= 1'b0;
	endtask
	task automatic axi_read(input addr_t a, input logic [33:0] e);
		int n;
		@(posedge i_clock);
		rd_q.push_back(e);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
			if (o_arready) i_arvalid <= 1'b0;
		end while ((i_arvalid || !o_rvalid) && n < 40);
		i_rready <= 1'b0;
	endtask
	// Pins are looked at after the synchroniser and decoder have settled
	task automatic check_pins(input int w, input logic [1:0] oe, input logic [1:0] out, input logic [1:0] m,
		input logic [1:0] lvl);
		repeat (w) @(posedge i_clock);
		cmp_pin("oe_n", oe, o_general_pin_oe_n);
		cmp_pin("pin_out", out, o_general_pin_out);
		cmp_pin("pin_level", lvl & m, o_pin_level & m);
	endtask

	// Oldest expectation is taken whenever an answer is accepted
	always @(posedge i_clock) begin
		if (o_bvalid && i_bready) cmp_bus("bresp", wr_q.pop_front(), {32'h0, o_bresp});
		if (o_rvalid && i_rready) cmp_bus("rdata", rd_q.pop_front(), {o_rresp, o_rdata});
	end

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		forever #2 i_clock = ~i_clock;
	end
	// The PWM sweep dominates the run at about 65300 cycles
	initial begin
		#400000;
		num_errors++;
		print_verdict();
	end
	initial begin
		logic [31:0] d;
		int t;
		void'($urandom(96));
		repeat (16) @(posedge i_clock);
		i_arst_n <= 1'b1;
		axi_read(`ADDR_CFG, {`RESP_OKAY, 32'h00008000});
		check_pins(6, 2'h3, 2'h0, 2'h3, 2'h2);
		// Random words cover direction, format, output value and spare bits
		for (int k = 0; k < 8; k++) begin
			d = $urandom();
			stat <= 2'($urandom());
			axi_write(`ADDR_CFG, d, 4'hF, `RESP_OKAY);
			axi_read(`ADDR_CFG, {`RESP_OKAY, 16'h0, 1'b1, d[14:0]});
			check_pins(6, ~d[9:8], d[9:8] & d[1:0], d[9:8] | ~d[11:10], (d[9:8] & d[1:0]) | (~d[9:8] & stat));
		end
		// Byte lanes, the status word, and the printed index as a bogus address
		axi_write(`ADDR_CFG, 32'h0, 4'hF, `RESP_OKAY);
		axi_write(`ADDR_CFG, 32'hFFFFFFFF, 4'h1, `RESP_OKAY);
		axi_write(`ADDR_STATUS, 32'hFFFF, 4'hF, `RESP_OKAY);
		axi_write(12'h081, 32'hFFFF, 4'hF, `RESP_SLVERR);
		axi_read(12'h081, {`RESP_SLVERR, 32'h0});
		axi_read(`ADDR_CFG, {`RESP_OKAY, 32'h000080FF});
		// Clock enable low freezes the sampled static level
		stat <= 2'h1;
		check_pins(6, 2'h3, 2'h0, 2'h3, 2'h1);
		i_clk_en <= 1'b0;
		stat <= 2'h2;
		check_pins(8, 2'h3, 2'h0, 2'h3, 2'h1);
		i_clk_en <= 1'b1;
		check_pins(6, 2'h3, 2'h0, 2'h3, 2'h2);
		// PWM decode on both pins for every time base code
		sel <= 2'h3;
		for (int c = 0; c < 4; c++) begin
			t = 16 << (2 * c);
			axi_write(`ADDR_CFG, 32'h0C00 | (c << 6) | (c << 4), 4'hF, `RESP_OKAY);
			hi <= 6 * t;
			lo <= 2 * t;
			check_pins(24 * t, 2'h3, 2'h0, 2'h3, 2'h3);
			hi <= 2 * t;
			lo <= 6 * t;
			check_pins(24 * t, 2'h3, 2'h0, 2'h3, 2'h0);
		end
		cmp_bus("pending", 34'h0, 34'(wr_q.size() + rd_q.size()));
		print_verdict();
	end
endmodule
